// file: bench/auth_server_model.sv
// stand-in for the authentication server behind the relay
`timescale 1ns/1ps
module auth_server_model (
  input wire logic clk,
  input wire port_access_gate_pkg::relay_t toServer,
  input wire logic [1:0] answer,
  input wire logic [3:0] delay,
  output port_access_gate_pkg::server_t server
);
  logic [3:0] wait_r = 4'h0;
  logic [3:0] port_r = 4'h0;
  initial server = '0;
  // answer 3 stays silent so the relay has to time out
  always @(posedge clk) begin
    server <= '0;
    if (toServer.valid === 1'b1) begin
      wait_r <= delay;
      port_r <= toServer.port;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
      if (wait_r == 4'h1 && answer != 2'h3) server <= {1'b1, port_r, answer};
    end
  end
endmodule : auth_server_model

// file: bench/port_access_gate_properties.sv
// assertions on the port access gate ports
`timescale 1ns/1ps
module port_access_gate_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire port_access_gate_pkg::ingress_t ingress,
  input wire port_access_gate_pkg::verdict_t verdict
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_verdict_follows: assert property (ingress.valid |=> verdict.valid)
    else $error("no verdict");
  a_verdict_port: assert property (verdict.valid |->
    $past(ingress.valid) && verdict.port == $past(ingress.port)) else $error("stray verdict");
  a_uplink_pass: assert property (ingress.valid && ingress.port[3] |=> verdict.forward)
    else $error("uplink dropped");
  a_known_kept: assert property (ingress.valid && ingress.srcKnown |=> !verdict.learn)
    else $error("known source relearned");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_single: assert property (rvalid |-> !arready)
    else $error("second read accepted");
endmodule : port_access_gate_properties
bind port_access_gate port_access_gate_properties chk (.clk, .nrst, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .ingress, .verdict);

// file: bench/tb_port_access_gate.sv
// random and directed bench for the port access gate
`timescale 1ns/1ps
module tb_port_access_gate;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, d, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r, ans = 2'h1;
  logic [3:0] dly = 4'h1;
  logic [7:0] linkUp = 8'hff, portOpen;
  port_access_gate_pkg::ingress_t ingress = '0;
  port_access_gate_pkg::portev_t ageOut = '0, idReq, toClient;
  port_access_gate_pkg::server_t server;
  port_access_gate_pkg::verdict_t verdict;
  port_access_gate_pkg::relay_t toServer;
  int fails = 0, check_count = 0, n, k, tc = 0, seed = 32'h26d0_6349;
  always #5 clk = ~clk;
  // one second is 20 cycles here
  port_access_gate #(.TICK_CYCLES(20)) DUT (.clk, .nrst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .linkUp, .ingress, .server, .ageOut,
    .verdict, .idReq, .toClient, .toServer, .portOpen);
  auth_server_model srv (.clk, .toServer, .answer(ans), .delay(dly), .server);
  // server frames relayed toward the port 0 client
  always @(posedge clk) if (toClient.valid === 1'b1 && toClient.port === 4'h0) tc++;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid} <= {20'h0_0000, a, v, 2'b11};
    for (i = 0; bvalid !== 1'b1 && i < 99; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    chk(32'({i < 99, bresp}), 32'h4);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int i;
    @(posedge clk);
    {araddr, arvalid} <= {20'h0_0000, a, 1'b1};
    for (i = 0; rvalid !== 1'b1 && i < 99; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    {d, r} = {rdata, rresp};
    chk(32'(i < 99), 32'h1);
  endtask : rd
  task automatic frame(input logic [3:0] p, input logic kn, input logic ea, input logic [1:0] kd);
    @(posedge clk);
    ingress <= {1'b1, p, kn, ea, kd};
    @(posedge clk);
    ingress <= '0;
    #1;
  endtask : frame
  task automatic vd(input logic [1:0] e);
    chk(32'({verdict.valid, verdict.forward, verdict.learn}), 32'({1'b1, e}));
  endtask : vd
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    fails++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(12'h008);
    chk(d, 32'h0002_3c1e);
    rd(12'h010);
    chk(d, 32'h0000_0340);
    rd(12'hffc);
    chk(32'(r), 32'h2);
    wr(12'h018, 32'h0000_0003);
    wr(12'h000, 32'h0000_0001);
    k = 0;
    repeat (40) begin
      d = $random(seed);
      dly <= {1'b0, d[6:4]} + 4'h1;
      if (d[1:0] == 2'h0 && k > 0) begin
        @(posedge clk) ageOut <= {1'b1, 4'h2};
        @(posedge clk) ageOut <= '0;
        k--;
      end
      frame(4'h2, d[2], 1'b0, 2'h0);
      vd(d[2] ? 2'b10 : {2{k < 3}});
      if (!d[2] && k < 3) k++;
    end
    rd(12'h038);
    chk(d & 32'h0000_01ff, {23'h00_0000, k == 3, 8'(k)});
    wr(12'h004, 32'h0000_0004);
    frame(4'h2, 1'b0, 1'b0, 2'h0);
    vd(2'b00);
    frame(4'h9, 1'b0, 1'b0, 2'h0);
    vd(2'b11);
    wr(12'h000, 32'h0000_0000);
    frame(4'h2, 1'b0, 1'b0, 2'h0);
    vd(2'b11);
    for (n = 0; n < 3; n++) begin
      frame(4'h0, 1'b1, 1'b1, 2'h0);
      vd(2'b00);
    end
    frame(4'h0, 1'b1, 1'b0, 2'h0);
    vd(2'b10);
    wr(12'h008, 32'h0002_0301);
    wr(12'h01c, 32'h0000_0240);
    wr(12'h020, 32'h0000_0140);
    wr(12'h000, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1 chk(32'(portOpen), 32'h0c);
    frame(4'h0, 1'b1, 1'b0, 2'h0);
    vd(2'b00);
    for (n = 1; n < 3; n++) begin
      ans <= 2'(n);
      frame(4'h0, 1'b1, 1'b1, 2'h0);
      chk(32'({idReq.valid, idReq.port}), 32'h10);
      frame(4'h0, 1'b1, 1'b1, 2'h2);
      chk(32'({toServer.valid, toServer.port}), 32'h10);
      repeat (12) @(posedge clk);
      #1 chk(32'(portOpen[0]), 32'(n == 1));
      frame(4'h0, 1'b1, 1'b1, 2'h1);
      chk(32'(portOpen[0]), 32'h0);
    end
    chk(32'(tc), 32'h2);
    linkUp <= 8'hdf;
    repeat (20) @(posedge clk);
    linkUp <= 8'hff;
    for (n = 0; !(idReq.valid === 1'b1 && idReq.port === 4'h5) && n < 40; n++)
      @(posedge clk) #1;
    chk(32'(n < 40), 32'h1);
    ans <= 2'h3;
    // a start is ignored while quiet, so wait the hold-off out first
    rd(12'h030);
    for (n = 0; d[14:12] === 3'h4 && n < 30; n++)
      rd(12'h030);
    frame(4'h0, 1'b1, 1'b1, 2'h0);
    frame(4'h0, 1'b1, 1'b1, 2'h2);
    for (n = 0; !(toServer.valid === 1'b1 && toServer.retry === 1'b1) && n < 99; n++)
      @(posedge clk) #1;
    chk(32'({toServer.retry, n > 4 && n < 99}), 32'h3);
    for (n = 0; d[14:12] !== 3'h4 && n < 30; n++)
      rd(12'h030);
    chk(32'({d[14:12], portOpen[0]}), 32'h8);
    test_done();
  end
endmodule : tb_port_access_gate

// file: common/port_access_gate_pkg.sv
// constants and types shared by the port access gate
package port_access_gate_pkg;
  localparam int NUM_ACCESS = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam logic [6:0] CEIL_MIN = 7'h01;
  localparam logic [6:0] CEIL_MAX = 7'h40;
  localparam logic [6:0] CEIL_RST = CEIL_MAX;
  localparam logic [7:0] TX_PERIOD_RST_S = 8'h1e;
  localparam logic [7:0] QUIET_RST_S = 8'h3c;
  localparam logic [3:0] MAX_REQ_RST = 4'h2;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_LOCK = 12'h004;
  localparam logic [11:0] OFF_TIMING = 12'h008;
  localparam logic [11:0] OFF_CFG = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h030;
  localparam int CTRL_LIMIT_EN_BIT = 0;
  localparam int CTRL_AUTH_EN_BIT = 1;
  localparam int TIM_QUIET_LSB = 8;
  localparam int TIM_MAXREQ_LSB = 16;
  localparam int CFG_MODE_LSB = 8;
  localparam int STAT_LIMITING_BIT = 8;
  localparam int STAT_AUTH_BIT = 9;
  localparam int STAT_STATE_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {BYPASS_SETTING, FORCED_UNAUTHORIZED_SETTING,
    FORCED_AUTHORIZED_SETTING, OUTCOME_DRIVEN_AUTHORIZATION} authmode_t;
  typedef enum logic [2:0] {AUTH_UNAUTH, AUTH_WAIT_CLIENT, AUTH_WAIT_SERVER,
    AUTH_AUTHORIZED, AUTH_QUIET} authstate_t;
  typedef enum logic [1:0] {EAPOL_START, EAPOL_LOGOFF, EAPOL_PACKET} eapolkind_t;
  typedef enum logic [1:0] {SRV_CHALLENGE, SRV_ACCEPT, SRV_REJECT} srvkind_t;
  typedef struct packed {
    logic valid; logic [3:0] port; logic srcKnown; logic eapol; eapolkind_t kind;
  } ingress_t;
  typedef struct packed {logic valid; logic [3:0] port; srvkind_t kind;} server_t;
  typedef struct packed {logic valid; logic [3:0] port;} portev_t;
  typedef struct packed {logic valid; logic [3:0] port; logic forward; logic learn;} verdict_t;
  typedef struct packed {logic valid; logic [3:0] port; logic retry;} relay_t;
  typedef struct packed {
    logic [6:0] ceiling; authmode_t mode; logic [6:0] count; authstate_t auth;
    logic [7:0] timer; logic [3:0] retries; logic tickPend; logic needId;
  } port_t;
endpackage : port_access_gate_pkg

// file: verilog/port_access_gate.sv
// source learning limiter and 802.1X authenticator gate with AXI4-Lite registers
// Functional notes
// - each port holds a learning ceiling, programmable 1 to 64.
// - slots fill first come first served; earliest new sources are kept.
// - learned addresses stay until aging removes them, never displaced.
// - a freed slot takes the next unseen source on that port.
// - with limiting on, unknown sources are dropped, known ones forwarded.
// - a port can be locked so it learns no new source.
// - one global enable; cleared means no ceiling or blocking anywhere.
// - limiting applies to access ports 0 to 7 only, not uplinks.
// - ceiling and limiting status readable per port.
// - authentication ports start unauthorized after reset.
// - unauthorized ports pass only EAPOL traffic, both directions.
// - automatic mode sends identity request on link down-to-up.
// - EAPOL-Start is answered with an identity request.
// - client EAPOL payload relayed to server unchanged, header stripped.
// - server EAP frames relayed to client in Ethernet framing.
// - server accept makes the port authorized, passing all frames.
// - failure keeps port unauthorized but allows a later attempt.
// - unanswered requests are resent; after the limit, authentication fails.
// - logoff or link up-to-down returns port to unauthorized.
// - a silent client leaves the port unauthorized with no access.
// - with authentication disabled, received EAPOL frames are discarded.
// - per-port forced authorized, forced unauthorized, outcome driven, or bypass.
// - timeouts counted; session fails at configured maximum, default two.
// - retransmit waits a transmit period, default 30 seconds.
// - after failure, a quiet period, default 60 seconds, before reacquiring.
`timescale 1ns/1ps
module port_access_gate #(
  parameter int TICK_CYCLES = port_access_gate_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] linkUp,
  input wire port_access_gate_pkg::ingress_t ingress,
  input wire port_access_gate_pkg::server_t server,
  input wire port_access_gate_pkg::portev_t ageOut,
  output port_access_gate_pkg::verdict_t verdict,
  output port_access_gate_pkg::portev_t idReq,
  output port_access_gate_pkg::portev_t toClient,
  output port_access_gate_pkg::relay_t toServer,
  output logic [7:0] portOpen
);
  localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

  typedef struct packed {
    logic limitEn;
    logic authEn;
    logic [7:0] lock;
    logic [7:0] txPeriod;
    logic [7:0] quietPeriod;
    logic [3:0] maxReq;
    port_access_gate_pkg::port_t [7:0] ports;
    logic [7:0] linkMeta;
    logic [7:0] linkSync;
    logic [7:0] linkPrev;
    logic [26:0] tickCnt;
    logic [2:0] scanIdx;
    logic awHave;
    logic wHave;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    port_access_gate_pkg::verdict_t verdict;
    port_access_gate_pkg::portev_t idReq;
    port_access_gate_pkg::portev_t toClient;
    port_access_gate_pkg::relay_t toServer;
    logic [7:0] portOpen;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // port index of a per-port register, valid flag on top
  function automatic logic [3:0] portSlot(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    portSlot = {(a >= base) && (d < 12'h020) && (a[1:0] == 2'b00), d[4:2]};
  endfunction : portSlot

  function automatic logic limitingNow(input state_t s, input logic [2:0] i);
    limitingNow = s.limitEn && (s.lock[i] || s.ports[i].count >= s.ports[i].ceiling);
  endfunction : limitingNow

  // whether ordinary traffic may pass the port
  function automatic logic passes(input state_t s, input logic [2:0] i);
    passes = 1'b1;
    if (s.authEn) begin
      case (s.ports[i].mode)
        port_access_gate_pkg::FORCED_UNAUTHORIZED_SETTING: passes = 1'b0;
        port_access_gate_pkg::OUTCOME_DRIVEN_AUTHORIZATION:
          passes = s.ports[i].auth == port_access_gate_pkg::AUTH_AUTHORIZED;
        default: passes = 1'b1;
      endcase
    end
  endfunction : passes

  function automatic logic [32:0] regRead(input state_t s, input logic [11:0] a);
    logic [3:0] c;
    logic [3:0] t;
    logic [31:0] d;
    c = portSlot(a, port_access_gate_pkg::OFF_CFG);
    t = portSlot(a, port_access_gate_pkg::OFF_STAT);
    d = 32'h0000_0000;
    if (a == port_access_gate_pkg::OFF_CTRL) begin
      d[port_access_gate_pkg::CTRL_LIMIT_EN_BIT] = s.limitEn;
      d[port_access_gate_pkg::CTRL_AUTH_EN_BIT] = s.authEn;
    end else if (a == port_access_gate_pkg::OFF_LOCK) begin
      d[7:0] = s.lock;
    end else if (a == port_access_gate_pkg::OFF_TIMING) begin
      d[7:0] = s.txPeriod;
      d[port_access_gate_pkg::TIM_QUIET_LSB +: 8] = s.quietPeriod;
      d[port_access_gate_pkg::TIM_MAXREQ_LSB +: 4] = s.maxReq;
    end else if (c[3]) begin
      d[6:0] = s.ports[c[2:0]].ceiling;
      d[port_access_gate_pkg::CFG_MODE_LSB +: 2] = s.ports[c[2:0]].mode;
    end else if (t[3]) begin
      d[6:0] = s.ports[t[2:0]].count;
      d[port_access_gate_pkg::STAT_LIMITING_BIT] = limitingNow(s, t[2:0]);
      d[port_access_gate_pkg::STAT_AUTH_BIT] = passes(s, t[2:0]);
      d[port_access_gate_pkg::STAT_STATE_LSB +: 3] = s.ports[t[2:0]].auth;
    end
    regRead = {(a == port_access_gate_pkg::OFF_CTRL) || (a == port_access_gate_pkg::OFF_LOCK)
      || (a == port_access_gate_pkg::OFF_TIMING) || c[3] || t[3], d};
  endfunction : regRead

  // start a fresh exchange: identity request with a full transmit period
  function automatic port_access_gate_pkg::port_t beginId(input port_access_gate_pkg::port_t p,
    input logic [7:0] period);
    beginId = p;
    beginId.auth = port_access_gate_pkg::AUTH_WAIT_CLIENT;
    beginId.timer = period;
    beginId.retries = 4'h0;
    beginId.needId = 1'b0;
  endfunction : beginId

  always_comb begin
    logic [32:0] rd;
    logic [31:0] wm;
    logic [3:0] ws;
    logic [2:0] ii;
    logic [2:0] si;
    logic learnOk;
    logic srcOk;
    logic isAuto;
    logic [6:0] ce;
    rd = '0;
    wm = '0;
    ws = '0;
    ii = ingress.port[2:0];
    si = server.port[2:0];
    learnOk = 1'b0;
    srcOk = 1'b0;
    isAuto = 1'b0;
    ce = '0;
    s_nxt = s_r;
    s_nxt.verdict = '0;
    s_nxt.idReq = '0;
    s_nxt.toClient = '0;
    s_nxt.toServer = '0;
    // link pins come from the PHY side, so two flops before use
    s_nxt.linkMeta = linkUp;
    s_nxt.linkSync = s_r.linkMeta;
    s_nxt.linkPrev = s_r.linkSync;
    s_nxt.tickCnt = (s_r.tickCnt == TICK_LAST) ? 27'h000_0000 : s_r.tickCnt + 27'h000_0001;

    for (int p = 0; p < port_access_gate_pkg::NUM_ACCESS; p++) begin
      if (s_r.tickCnt == TICK_LAST) begin
        s_nxt.ports[p].tickPend = 1'b1;
      end
      // no session runs while authentication is off, so no stray requests
      if (!s_r.authEn
          || s_r.ports[p].mode != port_access_gate_pkg::OUTCOME_DRIVEN_AUTHORIZATION) begin
        s_nxt.ports[p].auth = port_access_gate_pkg::AUTH_UNAUTH;
        s_nxt.ports[p].needId = 1'b0;
      end else if (s_r.linkSync[p] && !s_r.linkPrev[p]) begin
        s_nxt.ports[p].needId = 1'b1;
      end else if (!s_r.linkSync[p] && s_r.linkPrev[p]) begin
        s_nxt.ports[p].auth = port_access_gate_pkg::AUTH_UNAUTH;
        s_nxt.ports[p].needId = 1'b0;
      end
    end

    // ingress decision, learning and EAPOL consumption
    if (ingress.valid) begin
      s_nxt.verdict.valid = 1'b1;
      s_nxt.verdict.port = ingress.port;
      if (ingress.port >= 4'(port_access_gate_pkg::NUM_ACCESS)) begin
        s_nxt.verdict.forward = 1'b1;
        s_nxt.verdict.learn = !ingress.srcKnown;
      end else begin
        isAuto = s_nxt.ports[ii].mode == port_access_gate_pkg::OUTCOME_DRIVEN_AUTHORIZATION;
        learnOk = !ingress.srcKnown && !(s_r.limitEn && s_r.lock[ii]);
        if (s_r.limitEn && s_nxt.ports[ii].count >= s_nxt.ports[ii].ceiling) begin
          learnOk = 1'b0;
        end
        srcOk = !s_r.limitEn || ingress.srcKnown || learnOk;
        if (ingress.eapol && !s_r.authEn) begin
          s_nxt.verdict.forward = 1'b0;
        end else if (ingress.eapol
            && s_nxt.ports[ii].mode != port_access_gate_pkg::BYPASS_SETTING) begin
          s_nxt.verdict.forward = 1'b0;
          if (isAuto) begin
            case (ingress.kind)
              port_access_gate_pkg::EAPOL_START: begin
                if (s_nxt.ports[ii].auth != port_access_gate_pkg::AUTH_QUIET) begin
                  s_nxt.ports[ii] = beginId(s_nxt.ports[ii], s_r.txPeriod);
                  s_nxt.idReq = '{valid: 1'b1, port: ingress.port};
                end
              end
              port_access_gate_pkg::EAPOL_LOGOFF: begin
                if (s_nxt.ports[ii].auth != port_access_gate_pkg::AUTH_QUIET) begin
                  s_nxt.ports[ii].auth = port_access_gate_pkg::AUTH_UNAUTH;
                end
              end
              port_access_gate_pkg::EAPOL_PACKET: begin
                if (s_nxt.ports[ii].auth == port_access_gate_pkg::AUTH_WAIT_CLIENT) begin
                  s_nxt.ports[ii].auth = port_access_gate_pkg::AUTH_WAIT_SERVER;
                  s_nxt.ports[ii].timer = s_r.txPeriod;
                  s_nxt.ports[ii].retries = 4'h0;
                  // payload leaves untouched; the framer swaps the header
                  s_nxt.toServer = '{valid: 1'b1, port: ingress.port, retry: 1'b0};
                end
              end
              default: begin
              end
            endcase
          end
        end else begin
          s_nxt.verdict.forward = srcOk && passes(s_r, ii);
          s_nxt.verdict.learn = learnOk;
          if (learnOk && s_r.limitEn) begin
            s_nxt.ports[ii].count = s_nxt.ports[ii].count + 7'h01;
          end
        end
      end
    end

    // answers from the authentication server
    if (server.valid && !server.port[3]
        && s_nxt.ports[si].mode == port_access_gate_pkg::OUTCOME_DRIVEN_AUTHORIZATION
        && s_nxt.ports[si].auth == port_access_gate_pkg::AUTH_WAIT_SERVER) begin
      s_nxt.toClient = '{valid: 1'b1, port: server.port};
      case (server.kind)
        port_access_gate_pkg::SRV_ACCEPT: begin
          s_nxt.ports[si].auth = port_access_gate_pkg::AUTH_AUTHORIZED;
        end
        port_access_gate_pkg::SRV_REJECT: begin
          s_nxt.ports[si].auth = port_access_gate_pkg::AUTH_QUIET;
          s_nxt.ports[si].timer = s_r.quietPeriod;
        end
        default: begin
          s_nxt.ports[si].auth = port_access_gate_pkg::AUTH_WAIT_CLIENT;
          s_nxt.ports[si].timer = s_r.txPeriod;
          s_nxt.ports[si].retries = 4'h0;
        end
      endcase
    end

    if (ageOut.valid && !ageOut.port[3] && s_nxt.ports[ageOut.port[2:0]].count != 7'h00) begin
      s_nxt.ports[ageOut.port[2:0]].count = s_nxt.ports[ageOut.port[2:0]].count - 7'h01;
    end

    // one port per cycle serves timers and pending requests, so the
    // output strobes never collide; it yields to ingress and server traffic
    if (!ingress.valid && !server.valid) begin
      si = s_r.scanIdx;
      s_nxt.scanIdx = s_r.scanIdx + 3'h1;
      if (s_nxt.ports[si].needId
          && s_nxt.ports[si].auth == port_access_gate_pkg::AUTH_UNAUTH) begin
        s_nxt.ports[si] = beginId(s_nxt.ports[si], s_r.txPeriod);
        s_nxt.idReq = '{valid: 1'b1, port: {1'b0, si}};
      end else if (s_nxt.ports[si].tickPend) begin
        // a tick landing in this very cycle stays pending if an older pending tick is served now
        s_nxt.ports[si].tickPend = s_r.ports[si].tickPend && (s_r.tickCnt == TICK_LAST);
        // expire one tick after zero, so a wait is never cut short
        if (s_nxt.ports[si].timer != 8'h00) begin
          s_nxt.ports[si].timer = s_nxt.ports[si].timer - 8'h01;
        end else begin
          case (s_nxt.ports[si].auth)
            port_access_gate_pkg::AUTH_QUIET: begin
              s_nxt.ports[si].auth = port_access_gate_pkg::AUTH_UNAUTH;
              s_nxt.ports[si].needId = s_r.linkSync[si];
            end
            port_access_gate_pkg::AUTH_WAIT_CLIENT,
            port_access_gate_pkg::AUTH_WAIT_SERVER: begin
              if (s_nxt.ports[si].retries + 4'h1 >= s_r.maxReq) begin
                s_nxt.ports[si].auth = port_access_gate_pkg::AUTH_QUIET;
                s_nxt.ports[si].timer = s_r.quietPeriod;
              end else begin
                s_nxt.ports[si].retries = s_nxt.ports[si].retries + 4'h1;
                s_nxt.ports[si].timer = s_r.txPeriod;
                if (s_nxt.ports[si].auth == port_access_gate_pkg::AUTH_WAIT_CLIENT) begin
                  s_nxt.idReq = '{valid: 1'b1, port: {1'b0, si}};
                end else begin
                  s_nxt.toServer = '{valid: 1'b1, port: {1'b0, si}, retry: 1'b1};
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // AXI4-Lite write: address and data taken in either order
    if (awvalid && s_r.awready) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = awaddr[11:0];
    end
    if (wvalid && s_r.wready) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.awHave && s_r.wHave && !s_r.bvalid) begin
      rd = regRead(s_r, s_r.awAddr);
      for (int b = 0; b < 4; b++) begin
        wm[b*8 +: 8] = s_r.wStrb[b] ? s_r.wData[b*8 +: 8] : rd[b*8 +: 8];
      end
      ws = portSlot(s_r.awAddr, port_access_gate_pkg::OFF_CFG);
      if (s_r.awAddr == port_access_gate_pkg::OFF_CTRL) begin
        s_nxt.limitEn = wm[port_access_gate_pkg::CTRL_LIMIT_EN_BIT];
        s_nxt.authEn = wm[port_access_gate_pkg::CTRL_AUTH_EN_BIT];
      end else if (s_r.awAddr == port_access_gate_pkg::OFF_LOCK) begin
        s_nxt.lock = wm[7:0];
      end else if (s_r.awAddr == port_access_gate_pkg::OFF_TIMING) begin
        s_nxt.txPeriod = wm[7:0];
        s_nxt.quietPeriod = wm[port_access_gate_pkg::TIM_QUIET_LSB +: 8];
        s_nxt.maxReq = wm[port_access_gate_pkg::TIM_MAXREQ_LSB +: 4];
      end else if (ws[3]) begin
        ce = wm[6:0];
        if (ce < port_access_gate_pkg::CEIL_MIN) begin
          ce = port_access_gate_pkg::CEIL_MIN;
        end else if (ce > port_access_gate_pkg::CEIL_MAX) begin
          ce = port_access_gate_pkg::CEIL_MAX;
        end
        s_nxt.ports[ws[2:0]].ceiling = ce;
        s_nxt.ports[ws[2:0]].mode =
          port_access_gate_pkg::authmode_t'(wm[port_access_gate_pkg::CFG_MODE_LSB +: 2]);
      end
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rd[32] ? port_access_gate_pkg::RESP_OKAY : port_access_gate_pkg::RESP_SLVERR;
    end
    s_nxt.awready = !s_nxt.awHave && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.wHave && !s_nxt.bvalid;

    // AXI4-Lite read: one outstanding, answer the cycle after arrival
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      rd = regRead(s_r, araddr[11:0]);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd[31:0];
      s_nxt.rresp = rd[32] ? port_access_gate_pkg::RESP_OKAY : port_access_gate_pkg::RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    for (int p = 0; p < port_access_gate_pkg::NUM_ACCESS; p++) begin
      s_nxt.portOpen[p] = passes(s_nxt, 3'(p));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.txPeriod <= port_access_gate_pkg::TX_PERIOD_RST_S;
      s_r.quietPeriod <= port_access_gate_pkg::QUIET_RST_S;
      s_r.maxReq <= port_access_gate_pkg::MAX_REQ_RST;
      for (int p = 0; p < port_access_gate_pkg::NUM_ACCESS; p++) begin
        s_r.ports[p].ceiling <= port_access_gate_pkg::CEIL_RST;
        s_r.ports[p].mode <= port_access_gate_pkg::OUTCOME_DRIVEN_AUTHORIZATION;
        s_r.ports[p].auth <= port_access_gate_pkg::AUTH_UNAUTH;
      end
      s_r.portOpen <= 8'hff;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign verdict = s_r.verdict;
  assign idReq = s_r.idReq;
  assign toClient = s_r.toClient;
  assign toServer = s_r.toServer;
  assign portOpen = s_r.portOpen;
endmodule : port_access_gate
